// ---- verilog/clock_mode_defs.svh ----
// Register offsets, field positions, power mode codes and timing counts of the clock and mode block
`ifndef CLOCK_MODE_DEFS_SVH
`define CLOCK_MODE_DEFS_SVH

`define OFF_OSC_CTRL      8'h00
`define OFF_STATUS        8'h04
`define OFF_CONFIG        8'h08
`define OFF_WAKE_EN       8'h0C

`define OSC_SEL_BIT       0
`define OSC_STOP_BIT      1
`define OSC_PMODE_LO      2
`define OSC_PMODE_HI      3

`define STAT_PD_BIT       3
`define STAT_TO_BIT       4
`define STAT_MODE_LO      8
`define STAT_SETTLE_BIT   12
`define STAT_VECTOR_BIT   13

`define CFG_DIV4_BIT      0
`define CFG_START_FAST    1
`define CFG_XTAL_BIT      2
`define CFG_CLKOUT_BIT    3
`define CFG_RC_LO         4
`define CFG_RC_HI         6
`define CFG_GIE_BIT       8

`define PMODE_RUN         2'h0
`define PMODE_HALT        2'h1
`define PMODE_STBY        2'h2

`define WAKE_XTAL_CYCLES  10'h200
`define WAKE_RC_CYCLES    10'h010

`endif

// ---- verilog/clock_mode_pkg.sv ----
// Types shared by the clock and mode block
package clock_mode_pkg;
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_SLOW,
      MODE_STANDBY,
      MODE_HALT,
      MODE_SETTLE
   } op_mode_t;
endpackage

// ---- verilog/clock_mode_ctrl.sv ----
// Dual clock selection and power mode control with an AHB-Lite register slave
`include "clock_mode_defs.svh"

// Operation
// (RULE_01) High clock select 1 picks fast oscillator, 0 picks slow oscillator.
// (RULE_02) Instruction clock is system clock divided by two or four per option.
// (RULE_03) After reset start in Normal if startup option fast, else Slow.
// (RULE_04) Normal runs fast clock, slow oscillator keeps running, peripherals per enables.
// (RULE_05) Writing select 0 goes to Slow, writing 1 returns to Normal.
// (RULE_06) Slow mode keeps fast oscillator; only stop bit written 1 stops it.
// (RULE_07) Software switches to Slow before stopping fast oscillator, never together.
// (RULE_08) Power mode field bits 3:2 written 10b enters Standby.
// (RULE_09) Sleep instruction or field written 01b enters Halt.
// (RULE_10) Halt entry clears power-down flag, sets timeout flag, clears watchdog.
// (RULE_11) Halt stops execution, peripherals and both oscillators.
// (RULE_12) Standby stops execution; slow oscillator and enabled timers keep running.
// (RULE_13) Standby wakes on timer, watchdog, pin change or external interrupt.
// (RULE_14) Halt wakes only on watchdog, pin change or external interrupt.
// (RULE_15) After wake resume Normal if select is 1, Slow if 0.
// (RULE_16) Fast stop with Halt entry in one write is accepted.
// (RULE_17) Internal fast RC frequency chosen among 1,2,4,8,16,20 MHz.
// (RULE_18) Without crystal, oscillator pins are I/O, one may output instruction clock.
// (RULE_19) Halt wake waits 512 cycles with crystal, otherwise 16.
// (RULE_20) With global interrupts enabled, wake branches to vector, else continues.
// (RULE_21) Wake returns power mode field to its running value.
module clock_mode_ctrl (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        sleep_exec,
   input  wire logic        clear_watchdog_exec,
   input  wire logic        global_irq_enable,
   input  wire logic [3:0]  timer_wake,
   input  wire logic [3:0]  timer_enable,
   input  wire logic        watchdog_wake,
   input  wire logic        pin_change_wake,
   input  wire logic        ext_irq_wake,
   input  wire logic        startup_fast_strap,
   output logic             fast_osc_run,
   output logic             slow_osc_run,
   output logic             sys_clk_is_fast,
   output logic             inst_clk_en,
   output logic             cpu_run,
   output logic             periph_enable,
   output logic [3:0]       timer_active,
   output logic             watchdog_clear,
   output logic             wake_to_vector,
   output logic             crystal_in_pin_is_io,
   output logic             crystal_out_pin_is_io,
   output logic             crystal_out_pin_clk,
   output logic [2:0]       fast_rc_freq_sel
);

   clock_mode_pkg::op_mode_t mode_r;
   clock_mode_pkg::op_mode_t mode_nxt;

   logic        high_clock_select_r;
   logic        fast_osc_stop_r;
   logic [1:0]  power_mode_field_r;
   logic        power_down_flag_r;
   logic        timeout_flag_r;
   logic [8:0]  config_r;
   logic        cfg_loaded_r;
   logic [9:0]  settle_cnt_r;
   logic        vector_r;
   logic        gie_entry_r;
   logic [1:0]  div_cnt_r;
   logic        wdog_clr_r;
   logic [31:0] hrdata_r;
   logic        sync_a_r;
   logic        sync_b_r;

   logic        ph_valid_r;
   logic        ph_write_r;
   logic [7:0]  ph_addr_r;

   logic        wr_osc;
   logic        wr_cfg;
   logic [1:0]  wr_pmode;
   logic        enter_halt;
   logic        enter_stby;
   logic        wake_stby;
   logic        wake_halt;
   logic        running;

   function automatic logic sel_mode(input logic sel);
      sel_mode = sel;
   endfunction

   // Running mode picked by a select value
   function automatic clock_mode_pkg::op_mode_t run_mode(input logic sel);
      run_mode = sel_mode(sel) ? clock_mode_pkg::MODE_NORMAL : clock_mode_pkg::MODE_SLOW;
   endfunction

   // Strap comes from a pin: two flops before use
   always_ff @(posedge clock) begin
      sync_a_r <= startup_fast_strap;
      sync_b_r <= sync_a_r;
   end

   // AHB-Lite address phase capture; every access completes with zero wait
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r  <= 8'h00;
      end else if (hready) begin
         ph_valid_r <= hsel && htrans[1];
         ph_write_r <= hwrite;
         ph_addr_r  <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign wr_osc   = ph_valid_r && ph_write_r && (ph_addr_r == `OFF_OSC_CTRL);
   assign wr_cfg   = ph_valid_r && ph_write_r && (ph_addr_r == `OFF_CONFIG);
   assign wr_pmode = hwdata[`OSC_PMODE_HI:`OSC_PMODE_LO];
   assign running  = (mode_r == clock_mode_pkg::MODE_NORMAL) ||
                     (mode_r == clock_mode_pkg::MODE_SLOW);

   // Sleep only counts while the core executes
   assign enter_halt = running && (sleep_exec ||
                       (wr_osc && wr_pmode == `PMODE_HALT)); // RULE_09
   assign enter_stby = running && !sleep_exec &&
                       wr_osc && wr_pmode == `PMODE_STBY; // RULE_08
   assign wake_stby  = (|timer_wake) || watchdog_wake ||
                       pin_change_wake || ext_irq_wake; // RULE_13
   assign wake_halt  = watchdog_wake || pin_change_wake || ext_irq_wake; // RULE_14

   // Configuration options; first cycle after reset release picks strap, bus writes load them after
   always_ff @(posedge clock) begin
      if (!nrst) begin
         config_r     <= 9'h000;
         cfg_loaded_r <= 1'b0;
      end else if (!cfg_loaded_r) begin
         config_r[`CFG_START_FAST] <= sync_b_r;
         cfg_loaded_r              <= 1'b1;
      end else if (wr_cfg) begin
         config_r <= hwdata[8:0];
      end
   end

   // Oscillator control register
   always_ff @(posedge clock) begin
      if (!nrst) begin
         high_clock_select_r <= 1'b1;
         fast_osc_stop_r     <= 1'b0;
      end else if (!cfg_loaded_r) begin
         high_clock_select_r <= sync_b_r; // RULE_03
      end else if (wr_osc) begin
         high_clock_select_r <= hwdata[`OSC_SEL_BIT]; // RULE_05
         fast_osc_stop_r     <= hwdata[`OSC_STOP_BIT]; // RULE_06 RULE_16
      end
   end

   // Power mode field mirrors the mode; returns to run value on wake
   always_ff @(posedge clock) begin
      if (!nrst) begin
         power_mode_field_r <= `PMODE_RUN;
      end else if (enter_halt) begin
         power_mode_field_r <= `PMODE_HALT;
      end else if (enter_stby) begin
         power_mode_field_r <= `PMODE_STBY;
      end else if (mode_nxt == clock_mode_pkg::MODE_NORMAL ||
                   mode_nxt == clock_mode_pkg::MODE_SLOW) begin
         power_mode_field_r <= `PMODE_RUN; // RULE_21
      end
   end

   // Mode machine
   // A sleep request in the same write wins over its select change
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         clock_mode_pkg::MODE_NORMAL,
         clock_mode_pkg::MODE_SLOW: begin
            if (enter_halt) begin
               mode_nxt = clock_mode_pkg::MODE_HALT;
            end else if (enter_stby) begin
               mode_nxt = clock_mode_pkg::MODE_STANDBY;
            end else if (wr_osc) begin
               mode_nxt = run_mode(hwdata[`OSC_SEL_BIT]); // RULE_05
            end else if (!cfg_loaded_r) begin
               mode_nxt = run_mode(sync_b_r); // RULE_03
            end
         end
         clock_mode_pkg::MODE_STANDBY: begin
            // No settle time: an oscillator is still running
            if (wake_stby) begin
               mode_nxt = run_mode(high_clock_select_r); // RULE_15
            end
         end
         clock_mode_pkg::MODE_HALT: begin
            if (wake_halt) begin
               mode_nxt = clock_mode_pkg::MODE_SETTLE;
            end
         end
         clock_mode_pkg::MODE_SETTLE: begin
            if (settle_cnt_r == 10'h001) begin
               mode_nxt = run_mode(high_clock_select_r); // RULE_15
            end
         end
         default: begin
            mode_nxt = clock_mode_pkg::MODE_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         mode_r <= clock_mode_pkg::MODE_NORMAL;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Oscillator settle count after Halt wake
   always_ff @(posedge clock) begin
      if (!nrst) begin
         settle_cnt_r <= 10'h000;
      end else if (mode_r == clock_mode_pkg::MODE_HALT && wake_halt) begin
         settle_cnt_r <= config_r[`CFG_XTAL_BIT] ? `WAKE_XTAL_CYCLES
                                                 : `WAKE_RC_CYCLES; // RULE_19
      end else if (settle_cnt_r != 10'h000) begin
         settle_cnt_r <= settle_cnt_r - 10'h001;
      end
   end

   // Interrupt enable is taken as software left it when sleep starts
   always_ff @(posedge clock) begin
      if (!nrst) begin
         gie_entry_r <= 1'b0;
      end else if (enter_halt || enter_stby) begin
         gie_entry_r <= global_irq_enable || config_r[`CFG_GIE_BIT]; // RULE_20
      end
   end

   // Vector branch pulse on wake, held one cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         vector_r <= 1'b0;
      end else begin
         vector_r <= !running && (mode_nxt == clock_mode_pkg::MODE_NORMAL ||
                     mode_nxt == clock_mode_pkg::MODE_SLOW) &&
                     gie_entry_r; // RULE_20
      end
   end

   // Status flags; Halt entry beats a watchdog clear in the same cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         power_down_flag_r <= 1'b1;
         timeout_flag_r    <= 1'b1;
      end else if (enter_halt) begin
         power_down_flag_r <= 1'b0; // RULE_10
         timeout_flag_r    <= 1'b1; // RULE_10
      end else if (clear_watchdog_exec) begin
         power_down_flag_r <= 1'b1;
         timeout_flag_r    <= 1'b1;
      end else if (watchdog_wake) begin
         timeout_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wdog_clr_r <= 1'b0;
      end else begin
         wdog_clr_r <= enter_halt; // RULE_10
      end
   end

   // Instruction clock enable; counts only while executing
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_cnt_r <= 2'h0;
      end else if (!running) begin
         div_cnt_r <= 2'h0;
      end else if (config_r[`CFG_DIV4_BIT]) begin
         div_cnt_r <= div_cnt_r + 2'h1; // RULE_02
      end else begin
         div_cnt_r <= {1'b0, ~div_cnt_r[0]}; // RULE_02
      end
   end

   // Register read data
   // Taken at the address phase so it stands through the whole data phase
   always_ff @(posedge clock) begin
      if (!nrst) begin
         hrdata_r <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr == `OFF_OSC_CTRL) begin
            hrdata_r <= {28'h0000000, power_mode_field_r,
                         fast_osc_stop_r, high_clock_select_r};
         end else if (haddr == `OFF_STATUS) begin
            hrdata_r <= {18'h00000, vector_r, (settle_cnt_r != 10'h000),
                         1'b0, mode_r, 3'h0, timeout_flag_r,
                         power_down_flag_r, 3'h0};
         end else if (haddr == `OFF_CONFIG) begin
            hrdata_r <= {23'h000000, config_r};
         end else begin
            hrdata_r <= 32'h0000_0000;
         end
      end
   end

   assign hrdata = hrdata_r;

   // Clock and mode outputs
   always_comb begin
      sys_clk_is_fast = high_clock_select_r; // RULE_01
      cpu_run         = running;
      periph_enable   = running; // RULE_04 RULE_12
      slow_osc_run    = mode_r != clock_mode_pkg::MODE_HALT; // RULE_04 RULE_11 RULE_12
      fast_osc_run    = !fast_osc_stop_r && mode_r != clock_mode_pkg::MODE_HALT; // RULE_11
      timer_active    = (mode_r == clock_mode_pkg::MODE_HALT) ? 4'h0
                                                              : timer_enable; // RULE_12
      inst_clk_en     = running && div_cnt_r == 2'h0;
   end

   assign watchdog_clear        = wdog_clr_r;
   assign wake_to_vector        = vector_r;
   assign fast_rc_freq_sel      = config_r[`CFG_RC_HI:`CFG_RC_LO]; // RULE_17
   assign crystal_in_pin_is_io  = !config_r[`CFG_XTAL_BIT]; // RULE_18
   assign crystal_out_pin_is_io = !config_r[`CFG_XTAL_BIT] && !config_r[`CFG_CLKOUT_BIT];
   // Pin follows the instruction clock phase, so it tracks the divider setting
   assign crystal_out_pin_clk   = !config_r[`CFG_XTAL_BIT] && config_r[`CFG_CLKOUT_BIT] &&
                                  (config_r[`CFG_DIV4_BIT] ? div_cnt_r[1]
                                                           : div_cnt_r[0]); // RULE_18

endmodule

// ---- bench/wake_source.sv ----
// Model of the wake event sources that sit beyond the block
module wake_source (
   input  wire logic       clock,
   output logic      [3:0] timer_wake,
   output logic            watchdog_wake,
   output logic            pin_change_wake,
   output logic            ext_irq_wake
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {timer_wake, watchdog_wake, pin_change_wake, ext_irq_wake} = 7'h00;
   end
   // Kind 0 timer, 1 watchdog, 2 pin change, 3 external; held for one sampling edge
   task automatic pulse(input int kind, input logic [3:0] bits);
      case (kind)
         0: timer_wake <= bits;
         1: watchdog_wake <= 1'b1;
         2: pin_change_wake <= 1'b1;
         default: ext_irq_wake <= 1'b1;
      endcase
      @(posedge clock);
      {timer_wake, watchdog_wake, pin_change_wake, ext_irq_wake} <= 7'h00;
   endtask
endmodule

// ---- bench/clock_mode_props.sv ----
// Checker of mode and clock outputs of the clock and mode block
module clock_mode_props (
   input wire logic       clock,
   input wire logic       nrst,
   input wire logic       sleep_exec,
   input wire logic       watchdog_wake,
   input wire logic       pin_change_wake,
   input wire logic       ext_irq_wake,
   input wire logic [3:0] timer_wake,
   input wire logic [3:0] timer_enable,
   input wire logic       fast_osc_run,
   input wire logic       slow_osc_run,
   input wire logic       sys_clk_is_fast,
   input wire logic       inst_clk_en,
   input wire logic       cpu_run,
   input wire logic       periph_enable,
   input wire logic [3:0] timer_active,
   input wire logic       watchdog_clear
);
   wire halted = !cpu_run && !slow_osc_run && !fast_osc_run;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   chk_sleep_halts: assert property (sleep_exec && cpu_run |-> ##[1:2] halted)
      else $error("sleep did not halt");
   chk_halt_wd_clear: assert property (sleep_exec && cpu_run |-> ##[1:3] watchdog_clear)
      else $error("no watchdog clear");
   chk_wd_clear_pulse: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear too long");
   chk_halt_quiet: assert property (halted |-> !periph_enable && timer_active == 4'h0)
      else $error("halt left logic on");
   chk_halt_timer_wake: assert property (halted && !watchdog_wake && !pin_change_wake
      && !ext_irq_wake |=> halted)
      else $error("halt left without event");
   chk_halt_wake_time: assert property (halted && (watchdog_wake || pin_change_wake
      || ext_irq_wake) |-> ##[1:530] cpu_run)
      else $error("halt wake too slow");
   chk_stby_wake_time: assert property (!cpu_run && slow_osc_run && timer_wake != 4'h0
      |-> ##[1:530] cpu_run)
      else $error("standby wake missing");
   chk_run_clocks: assert property (cpu_run |-> slow_osc_run && timer_active == timer_enable
      && (fast_osc_run || !sys_clk_is_fast))
      else $error("running clocks wrong");
   chk_inst_div: assert property (nrst && inst_clk_en |=> !inst_clk_en ##1
      (!inst_clk_en || $past(cpu_run, 2)))
      else $error("instruction clock too fast");
endmodule
bind clock_mode_ctrl clock_mode_props u_props (.clock(clock), .nrst(nrst),
   .sleep_exec(sleep_exec), .watchdog_wake(watchdog_wake), .pin_change_wake(pin_change_wake),
   .ext_irq_wake(ext_irq_wake), .timer_wake(timer_wake), .timer_enable(timer_enable),
   .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run), .cpu_run(cpu_run),
   .sys_clk_is_fast(sys_clk_is_fast), .inst_clk_en(inst_clk_en),
   .periph_enable(periph_enable), .timer_active(timer_active),
   .watchdog_clear(watchdog_clear));

// ---- bench/tb.sv ----
// Self-checking bench for the clock and power mode block
`include "clock_mode_defs.svh"
`define CHK(nm, got, ex) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
   $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock, nrst, hsel, hwrite, hreadyout, sleep_exec, clear_watchdog_exec;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, rd;
   logic        global_irq_enable, startup_fast_strap, watchdog_wake, pin_change_wake;
   logic        ext_irq_wake, fast_osc_run, slow_osc_run, sys_clk_is_fast, inst_clk_en;
   logic        cpu_run, periph_enable, xin_io, xout_io, xout_clk, sel, x, y;
   logic        hresp, wake_vec;
   logic [3:0]  timer_wake, timer_enable, timer_active;
   logic [2:0]  rc_sel;
   int          err_total, comparisons, cycles, n, k, vec_cnt, vc0;
   clock_mode_ctrl dut (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
      .clear_watchdog_exec(clear_watchdog_exec), .global_irq_enable(global_irq_enable),
      .timer_wake(timer_wake), .timer_enable(timer_enable), .watchdog_wake(watchdog_wake),
      .pin_change_wake(pin_change_wake), .ext_irq_wake(ext_irq_wake),
      .startup_fast_strap(startup_fast_strap), .fast_osc_run(fast_osc_run),
      .slow_osc_run(slow_osc_run), .sys_clk_is_fast(sys_clk_is_fast),
      .inst_clk_en(inst_clk_en), .cpu_run(cpu_run), .periph_enable(periph_enable),
      .timer_active(timer_active), .watchdog_clear(), .wake_to_vector(wake_vec),
      .crystal_in_pin_is_io(xin_io), .crystal_out_pin_is_io(xout_io),
      .crystal_out_pin_clk(xout_clk), .fast_rc_freq_sel(rc_sel));
   wake_source src (.clock(clock), .timer_wake(timer_wake), .watchdog_wake(watchdog_wake),
      .pin_change_wake(pin_change_wake), .ext_irq_wake(ext_irq_wake));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Wait ceiling well above the one long crystal settle of the run
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         final_report();
      end
   end
   // Vector pulses counted mid-cycle, where the registered pulse is settled
   always @(negedge clock) begin
      if (wake_vec === 1'b1) vec_cnt++;
   end
   function automatic logic [2:0] exp_mode(input logic s);
      return s ? 3'h0 : 3'h1;
   endfunction
   function automatic int exp_wait(input logic xtal);
      return xtal ? 512 : 16;
   endfunction
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK("hresp", hresp, 1'b0)
   endtask
   task automatic wosc(input logic s, input logic stop, input logic [1:0] m);
      bus(1'b1, `OFF_OSC_CTRL, {28'h0, m, stop, s});
      tick(2);
   endtask
   task automatic wait_run();
      n = 0;
      while (cpu_run !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
   endtask
   task automatic final_report();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      // One slave on the bus, so it stays selected
      {nrst, hsel, hwrite, sleep_exec, clear_watchdog_exec, global_irq_enable} = 6'h11;
      {haddr, htrans, hwdata, timer_enable} = 46'h0;
      startup_fast_strap = 1'b1;
      n = $urandom(82);
      tick(10);
      nrst <= 1'b1;
      tick(4);
      `CHK("start", {cpu_run, sys_clk_is_fast}, 2'h3)
      bus(1'b0, `OFF_STATUS, 32'h0);
      `CHK("reset_status", {rd[10:8], rd[4:3]}, 5'h03)
      bus(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", rd, 32'h0)
      for (k = 0; k < 2; k++) begin
         bus(1'b1, `OFF_CONFIG, 32'(k));
         tick(2);
         n = 0;
         repeat (40) begin
            @(negedge clock);
            n += inst_clk_en;
         end
         `CHK("inst_clk", n, k ? 10 : 20)
         @(posedge clock);
      end
      for (k = 0; k < 6; k++) begin
         x = 1'($urandom);
         y = 1'($urandom);
         bus(1'b1, `OFF_CONFIG, {25'h0, 3'(k), y, x, 2'h0});
         tick(1);
         `CHK("rc_freq", rc_sel, 3'(k))
         `CHK("pins_io", {xin_io, xout_io}, {~x, ~x & ~y})
         n = 0;
         repeat (8) begin
            @(negedge clock);
            n += xout_clk;
         end
         `CHK("clk_out", n, (!x && y) ? 4 : 0)
         @(posedge clock);
      end
      wosc(1'b0, 1'b0, 2'h0);
      `CHK("to_slow", {sys_clk_is_fast, fast_osc_run}, 2'h1)
      wosc(1'b0, 1'b1, 2'h0);
      `CHK("fast_stop", fast_osc_run, 1'b0)
      for (k = 0; k < 10; k++) begin
         sel = 1'($urandom);
         wosc(sel, 1'b0, 2'h0);
         bus(1'b0, `OFF_STATUS, 32'h0);
         `CHK("run_mode", {rd[10:8], sys_clk_is_fast}, {exp_mode(sel), sel})
      end
      for (k = 0; k < 4; k++) begin
         sel = 1'($urandom);
         timer_enable <= 4'($urandom);
         wosc(sel, 1'b0, 2'h0);
         wosc(sel, 1'b0, 2'h2);
         `CHK("stby", {cpu_run, slow_osc_run}, 2'h1)
         `CHK("stby_timers", timer_active, timer_enable)
         src.pulse(k, 4'h1 << k);
         wait_run();
         `CHK("stby_wake", n <= 3, 1'b1)
         bus(1'b0, `OFF_STATUS, 32'h0);
         `CHK("stby_mode", rd[10:8], exp_mode(sel))
         bus(1'b0, `OFF_OSC_CTRL, 32'h0);
         `CHK("stby_field", rd[3:2], 2'h0)
      end
      for (k = 0; k < 2; k++) begin
         global_irq_enable <= k[0];
         bus(1'b1, `OFF_CONFIG, {29'h0, k[0], 2'h0});
         wosc(k[0], 1'b0, 2'h0);
         vc0 = vec_cnt;
         if (k == 0) begin
            wosc(1'b0, 1'b1, 2'h1);
         end else begin
            sleep_exec <= 1'b1;
            @(posedge clock);
            sleep_exec <= 1'b0;
            tick(2);
         end
         `CHK("halt_off", {cpu_run, fast_osc_run, slow_osc_run}, 3'h0)
         src.pulse(0, 4'hF);
         tick(3);
         `CHK("halt_timer", cpu_run, 1'b0)
         src.pulse(2 + k, 4'h0);
         wait_run();
         `CHK("settle", n >= exp_wait(k[0]) && n <= exp_wait(k[0]) + 4, 1'b1)
         `CHK("vector", vec_cnt - vc0, k)
         bus(1'b0, `OFF_STATUS, 32'h0);
         `CHK("halt_stat", {rd[10:8], rd[4:3]}, {exp_mode(k[0]), 2'h2})
      end
      clear_watchdog_exec <= 1'b1;
      @(posedge clock);
      clear_watchdog_exec <= 1'b0;
      bus(1'b0, `OFF_STATUS, 32'h0);
      `CHK("flags_set", rd[4:3], 2'h3)
      // Second reset with the strap low must start in Slow mode
      startup_fast_strap <= 1'b0;
      nrst <= 1'b0;
      tick(4);
      nrst <= 1'b1;
      tick(4);
      `CHK("start_slow", {cpu_run, sys_clk_is_fast}, 2'h2)
      bus(1'b0, `OFF_STATUS, 32'h0);
      `CHK("slow_status", {rd[10:8], rd[4:3]}, 5'h07)
      final_report();
   end
endmodule
